/* pxc_pkg.sv */
// package for the extended phy control register block
package pxc_pkg;
    localparam logic [4:0]  PXC_REG_ADDR      = 5'h10;
    localparam int          PXC_BIT_OVR_EN    = 15;
    localparam int          PXC_ADDR_LSB      = 6;
    localparam int          PXC_ADDR_MSB      = 10;
    localparam int          PXC_BIT_SCR_TEST  = 5;
    localparam int          PXC_BIT_NRZI      = 3;
    localparam int          PXC_BIT_INV_CODE  = 2;
    localparam int          PXC_BIT_SCR_DIS   = 0;
    localparam logic [15:0] PXC_WR_MASK       = 16'h802d;
    localparam logic        PXC_RST_OVR_EN    = 1'b0;
    localparam logic        PXC_RST_SCR_TEST  = 1'b0;
    localparam logic        PXC_RST_NRZI      = 1'b1;
    localparam logic        PXC_RST_INV_CODE  = 1'b0;
    localparam logic        PXC_RST_SCR_DIS   = 1'b0;
    localparam int          PXC_LFSR_W        = 11;
    localparam logic [10:0] PXC_LFSR_SEED     = 11'h7ff;

    // management write request
    typedef struct packed {
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] data;
    } pxc_mgmt_wr_t;

    // mii transmit nibble
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] nib;
    } pxc_mii_tx_t;

    // control fields steering the data path
    typedef struct packed {
        logic scr_test;
        logic nrzi;
        logic inv_code;
        logic scr_dis;
    } pxc_ctrl_t;
endpackage : pxc_pkg

/* pxc_tx_encoder.sv */
// transmit nibble encoder, scrambler and nrz/nrzi line coder
`timescale 1ns/100ps
`default_nettype none
module pxc_tx_encoder (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // control
    input  wire pxc_pkg::pxc_ctrl_t ctrl,
    input  wire logic              speed_100,
    // mii side
    input  wire pxc_pkg::pxc_mii_tx_t mii_tx,
    // coded output
    output logic [4:0]             code_ff,
    output logic                   line_bit_ff
);
    import pxc_pkg::*;

    logic [PXC_LFSR_W-1:0] lfsr_ff;
    logic [4:0]            nxt_code;
    logic                  scr_bit;

    function automatic logic [4:0] std_4b5b(input logic [3:0] n);
        case (n)
            4'h0: std_4b5b = 5'h1e;
            4'h1: std_4b5b = 5'h09;
            4'h2: std_4b5b = 5'h14;
            4'h3: std_4b5b = 5'h15;
            4'h4: std_4b5b = 5'h0a;
            4'h5: std_4b5b = 5'h0b;
            4'h6: std_4b5b = 5'h0e;
            4'h7: std_4b5b = 5'h0f;
            4'h8: std_4b5b = 5'h12;
            4'h9: std_4b5b = 5'h13;
            4'ha: std_4b5b = 5'h16;
            4'hb: std_4b5b = 5'h17;
            4'hc: std_4b5b = 5'h1a;
            4'hd: std_4b5b = 5'h1b;
            4'he: std_4b5b = 5'h1c;
            default: std_4b5b = 5'h1d;
        endcase
    endfunction : std_4b5b

    function automatic logic [4:0] test_4b5b(input logic [3:0] n);
        case (n)
            4'h8: test_4b5b = 5'h00;
            4'h9: test_4b5b = 5'h0d;
            4'ha: test_4b5b = 5'h0c;
            4'hb: test_4b5b = 5'h11;
            4'hc: test_4b5b = 5'h10;
            4'hd: test_4b5b = 5'h19;
            4'he: test_4b5b = 5'h18;
            4'hf: test_4b5b = 5'h1f;
            default: test_4b5b = {1'b0, n}; // [R13]
        endcase
    endfunction : test_4b5b // [R14]

    always_comb begin
        if (!mii_tx.en) begin
            nxt_code = 5'h1f;
        end else if (ctrl.inv_code && mii_tx.er) begin
            nxt_code = test_4b5b(mii_tx.nib); // [R12]
        end else begin
            nxt_code = std_4b5b(mii_tx.nib); // [R11]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            code_ff <= 5'h1f;
        end else begin
            code_ff <= nxt_code;
        end
    end

    // scrambler only in 100 mode and when not disabled
    assign scr_bit = speed_100 && !ctrl.scr_dis && lfsr_ff[PXC_LFSR_W-1]; // [R15] [R16]

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lfsr_ff <= PXC_LFSR_SEED;
        end else begin
            lfsr_ff <= {lfsr_ff[PXC_LFSR_W-2:0], lfsr_ff[10] ^ lfsr_ff[8]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            line_bit_ff <= 1'b0;
        end else if (ctrl.nrzi && speed_100) begin
            line_bit_ff <= line_bit_ff ^ (code_ff[4] ^ scr_bit); // [R10]
        end else begin
            line_bit_ff <= code_ff[4] ^ scr_bit; // [R10]
        end
    end

    a_test_table_low: assert property (@(posedge clk_sys) disable iff (reset)
        (mii_tx.en && mii_tx.er && ctrl.inv_code && !mii_tx.nib[3]) |=> code_ff == {1'b0, $past(mii_tx.nib)})
        else $error("test code for low nibble wrong"); // [R13]
    a_test_table_idle: assert property (@(posedge clk_sys) disable iff (reset)
        (mii_tx.en && mii_tx.er && ctrl.inv_code && mii_tx.nib == 4'hf) |=> code_ff == 5'h1f)
        else $error("test code for 1111 wrong"); // [R14]
    a_std_when_off: assert property (@(posedge clk_sys) disable iff (reset)
        (mii_tx.en && !ctrl.inv_code && mii_tx.nib == 4'h0) |=> code_ff == 5'h1e)
        else $error("standard code not used"); // [R11]
    c_test_code: cover property (@(posedge clk_sys) mii_tx.en && mii_tx.er && ctrl.inv_code);
endmodule : pxc_tx_encoder
`default_nettype wire

/* pxc_ext_ctrl.sv */
// extended phy control register with strap capture and tx data path
// How it works
// [R1] override enable set lets the next management write change protected bits
// [R2] override enable clears itself after the next management write
// [R3] station must set override enable again before each protected write
// [R4] writes with override enable clear leave protected bits unchanged
// [R5] reserved bits 14:11, 4 and 1 read as zero
// [R6] station writes reserved bits with their default values
// [R7] address bits captured from strap pins at hardware reset, then held
// [R8] software reset leaves captured address untouched
// [R9] scrambler test bit forces receive lock loss; reset value zero
// [R10] nrz when encoding bit zero, nrzi when one; default one; code uses nrzi only at 100 mb/s, nrz at 10 mb/s
// [R11] invalid-code bit zero gives standard 4b/5b translation
// [R12] invalid-code bit one with tx error uses the test table
// [R13] test nibbles 0000..0111 sent as zero above the nibble
// [R14] test nibbles 1000..1111 sent as fixed listed codes
// [R15] scrambler disable bypasses both scrambler and descrambler
// [R16] scrambler applied only at 100 mb/s
`timescale 1ns/100ps
`default_nettype none
module pxc_ext_ctrl (
    // clock and resets
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  soft_reset,
    // strap pins
    input  wire logic                  addr_strap_bit4_pin,
    input  wire logic                  addr_strap_bit3_pin,
    input  wire logic                  addr_strap_bit2_pin,
    input  wire logic                  addr_strap_bit1_pin,
    input  wire logic                  addr_strap_bit0_pin,
    // management register access
    input  wire pxc_pkg::pxc_mgmt_wr_t mgmt_wr,
    input  wire logic [4:0]            mgmt_rd_addr,
    output logic [15:0]                mgmt_rd_data_ff,
    // to other registers of the set
    output logic                       override_protected_bit_ff,
    output logic [4:0]                 phy_addr_ff,
    // data path
    input  wire logic                  speed_100,
    input  wire pxc_pkg::pxc_mii_tx_t  mii_tx,
    output logic [4:0]                 tx_code_ff,
    output logic                       tx_line_bit_ff,
    output logic                       rx_scr_unlock_ff,
    output logic                       rx_descr_bypass_ff
);
    import pxc_pkg::*;

    logic      strap_pending_ff;
    logic      ovr_en_ff;
    pxc_ctrl_t ctrl_ff;
    logic      reg_wr;
    logic      any_wr;
    logic [4:0] tx_code;
    logic      tx_line_bit;

    assign any_wr = mgmt_wr.wr;
    assign reg_wr = mgmt_wr.wr && (mgmt_wr.addr == PXC_REG_ADDR);

    function automatic logic [15:0] pack_reg(input logic ovr, input logic [4:0] a, input pxc_ctrl_t c);
        logic [15:0] r;
        r = 16'h0000; // [R5]
        r[PXC_BIT_OVR_EN] = ovr;
        r[PXC_ADDR_MSB:PXC_ADDR_LSB] = a;
        r[PXC_BIT_SCR_TEST] = c.scr_test;
        r[PXC_BIT_NRZI] = c.nrzi;
        r[PXC_BIT_INV_CODE] = c.inv_code;
        r[PXC_BIT_SCR_DIS] = c.scr_dis;
        pack_reg = r & (PXC_WR_MASK | 16'h07c0);
    endfunction : pack_reg

    // strap sampled on the first clock after reset release, not under reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strap_pending_ff <= 1'b1;
        end else begin
            strap_pending_ff <= 1'b0;
        end
    end

    // soft reset deliberately not in this process
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phy_addr_ff <= 5'h00;
        end else if (strap_pending_ff) begin
            phy_addr_ff <= {addr_strap_bit4_pin, addr_strap_bit3_pin, addr_strap_bit2_pin,
                            addr_strap_bit1_pin, addr_strap_bit0_pin}; // [R7] [R8]
        end
    end

    // any management write consumes the enable; a write setting it re-arms
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            ovr_en_ff <= PXC_RST_OVR_EN;
        end else if (reg_wr) begin
            ovr_en_ff <= mgmt_wr.data[PXC_BIT_OVR_EN]; // [R1] [R3]
        end else if (any_wr) begin
            ovr_en_ff <= 1'b0; // [R2]
        end
    end

    // override window seen by protected bits in other registers
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            override_protected_bit_ff <= 1'b0;
        end else begin
            override_protected_bit_ff <= (ovr_en_ff && !any_wr) || (reg_wr && mgmt_wr.data[PXC_BIT_OVR_EN]); // [R1] [R4]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            ctrl_ff.scr_test <= PXC_RST_SCR_TEST;
            ctrl_ff.nrzi     <= PXC_RST_NRZI;
            ctrl_ff.inv_code <= PXC_RST_INV_CODE;
            ctrl_ff.scr_dis  <= PXC_RST_SCR_DIS;
        end else if (reg_wr) begin
            ctrl_ff.scr_test <= mgmt_wr.data[PXC_BIT_SCR_TEST]; // [R9]
            ctrl_ff.nrzi     <= mgmt_wr.data[PXC_BIT_NRZI]; // [R10]
            ctrl_ff.inv_code <= mgmt_wr.data[PXC_BIT_INV_CODE]; // [R12]
            ctrl_ff.scr_dis  <= mgmt_wr.data[PXC_BIT_SCR_DIS]; // [R15]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mgmt_rd_data_ff <= 16'h0000;
        end else if (mgmt_rd_addr == PXC_REG_ADDR) begin
            mgmt_rd_data_ff <= pack_reg(ovr_en_ff, phy_addr_ff, ctrl_ff); // [R5]
        end else begin
            mgmt_rd_data_ff <= 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_scr_unlock_ff   <= 1'b0;
            rx_descr_bypass_ff <= 1'b0;
        end else begin
            rx_scr_unlock_ff   <= ctrl_ff.scr_test; // [R9]
            rx_descr_bypass_ff <= ctrl_ff.scr_dis || !speed_100; // [R15] [R16]
        end
    end

    pxc_tx_encoder u_enc (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .ctrl        (ctrl_ff),
        .speed_100   (speed_100),
        .mii_tx      (mii_tx),
        .code_ff     (tx_code),
        .line_bit_ff (tx_line_bit)
    );

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_code_ff     <= 5'h1f;
            tx_line_bit_ff <= 1'b0;
        end else begin
            tx_code_ff     <= tx_code;
            tx_line_bit_ff <= tx_line_bit;
        end
    end

    a_ovr_self_clear: assert property (@(posedge clk_sys) disable iff (reset || soft_reset)
        (ovr_en_ff && any_wr && !reg_wr) |=> !ovr_en_ff)
        else $error("override enable did not clear"); // [R2]
    a_ovr_blocks: assert property (@(posedge clk_sys) disable iff (reset || soft_reset)
        (!ovr_en_ff && !reg_wr) |=> !override_protected_bit_ff)
        else $error("protected write allowed without enable"); // [R4]
    a_ovr_allows: assert property (@(posedge clk_sys) disable iff (reset || soft_reset)
        (reg_wr && mgmt_wr.data[PXC_BIT_OVR_EN]) |=> override_protected_bit_ff && ovr_en_ff)
        else $error("override not armed"); // [R1]
    a_resv_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (mgmt_rd_data_ff & 16'h7812) == 16'h0000)
        else $error("reserved bit reads nonzero"); // [R5]
    a_addr_held: assert property (@(posedge clk_sys) disable iff (reset)
        !strap_pending_ff |=> $stable(phy_addr_ff))
        else $error("phy address changed after capture"); // [R7] [R8]
    a_nrzi_reset: assert property (@(posedge clk_sys)
        (reset || soft_reset) |=> ctrl_ff.nrzi && !ctrl_ff.scr_test && !ctrl_ff.scr_dis)
        else $error("control reset values wrong"); // [R9] [R10]
    a_bypass_10m: assert property (@(posedge clk_sys) disable iff (reset)
        !speed_100 |=> rx_descr_bypass_ff)
        else $error("descrambler active at 10 mb/s"); // [R16]
    a_scr_unlock: assert property (@(posedge clk_sys) disable iff (reset)
        ctrl_ff.scr_test |=> rx_scr_unlock_ff)
        else $error("test mode did not force unlock"); // [R9]
    c_ovr_write: cover property (@(posedge clk_sys) ovr_en_ff && any_wr && !reg_wr);
    c_addr_read: cover property (@(posedge clk_sys) mgmt_rd_addr == PXC_REG_ADDR && !reset);
    c_scr_dis: cover property (@(posedge clk_sys) reg_wr && mgmt_wr.data[PXC_BIT_SCR_DIS]);
endmodule : pxc_ext_ctrl
`default_nettype wire

/* pxc_sta_model.sv */
// station management model issuing register writes and reads
`timescale 1ns/100ps
`default_nettype none
module pxc_sta_model (
    // clock
    input  wire logic             clk_sys,
    // management access
    output pxc_pkg::pxc_mgmt_wr_t mgmt_wr,
    output logic [4:0]            mgmt_rd_addr,
    input  wire logic [15:0]      mgmt_rd_data_ff
);
    import pxc_pkg::*;
    initial begin
        mgmt_wr      = '0;
        mgmt_rd_addr = 5'h00;
    end
    // reserved bits always go out at their zero default
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        mgmt_wr = '{1'b1, a, d & 16'h87ed};
        @(negedge clk_sys);
        mgmt_wr.wr = 1'b0;
    endtask : wr
    // each protected write needs its own arming write
    task automatic arm(input logic [15:0] d);
        wr(PXC_REG_ADDR, d | 16'h8000);
    endtask : arm
    task automatic rd(output logic [15:0] d);
        @(negedge clk_sys);
        mgmt_rd_addr = PXC_REG_ADDR;
        @(negedge clk_sys);
        d = mgmt_rd_data_ff;
        mgmt_rd_addr = 5'h00;
    endtask : rd
endmodule : pxc_sta_model
`default_nettype wire

/* tb_top.sv */
// self-checking testbench for the extended phy control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pxc_pkg::*;
    localparam logic [79:0] STD_TBL =
        80'b11101_11100_11011_11010_10111_10110_10011_10010_01111_01110_01011_01010_10101_10100_01001_11110;
    localparam logic [39:0] TST_TBL = 40'b11111_11000_11001_10000_10001_01100_01101_00000;
    logic         clk_sys    = 1'b0;
    logic         reset      = 1'b1;
    logic         soft_reset = 1'b0;
    logic         speed_100  = 1'b1;
    logic [4:0]   strap      = 5'h00;
    logic [4:0]   cap, phy_addr, tx_code;
    logic         ovr, line_bit, rx_unlock, rx_bypass;
    logic [15:0]  rd, ctl, mgmt_rd_data_ff;
    logic [4:0]   mgmt_rd_addr;
    pxc_mgmt_wr_t mgmt_wr;
    pxc_mii_tx_t  mii_tx     = '0;
    integer       errors = 0, samples_checked = 0, cycles = 0, seed = 32'h90b6d2ff;

    always #5 clk_sys = ~clk_sys;

    pxc_ext_ctrl uut (
        .clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset),
        .addr_strap_bit4_pin(strap[4]), .addr_strap_bit3_pin(strap[3]), .addr_strap_bit2_pin(strap[2]),
        .addr_strap_bit1_pin(strap[1]), .addr_strap_bit0_pin(strap[0]),
        .mgmt_wr(mgmt_wr), .mgmt_rd_addr(mgmt_rd_addr), .mgmt_rd_data_ff(mgmt_rd_data_ff),
        .override_protected_bit_ff(ovr), .phy_addr_ff(phy_addr),
        .speed_100(speed_100), .mii_tx(mii_tx), .tx_code_ff(tx_code), .tx_line_bit_ff(line_bit),
        .rx_scr_unlock_ff(rx_unlock), .rx_descr_bypass_ff(rx_bypass)
    );
    pxc_sta_model sta (
        .clk_sys(clk_sys), .mgmt_wr(mgmt_wr), .mgmt_rd_addr(mgmt_rd_addr),
        .mgmt_rd_data_ff(mgmt_rd_data_ff)
    );

    function automatic logic [4:0] exp_code(pxc_mii_tx_t t, logic inv);
        if (!t.en) return 5'h1f;
        if (inv && t.er) return t.nib[3] ? TST_TBL[t.nib[2:0]*5 +: 5] : {1'b0, t.nib};
        return STD_TBL[t.nib*5 +: 5];
    endfunction : exp_code
    function automatic logic [15:0] exp_reg(logic [15:0] d, logic [4:0] s);
        return (d & PXC_WR_MASK) | {5'h00, s, 6'h00};
    endfunction : exp_reg

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk_reg
    task automatic chk_code(input logic [4:0] got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: tx code got %b expected %b", $time, got, exp);
        end
    endtask : chk_code
    task automatic chk_line(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: line bit got %b expected %b", $time, got, exp);
        end
    endtask : chk_line
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic hw_reset;
        strap = 5'($random(seed));
        cap = strap;
        reset = 1'b1;
        repeat (3) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        // pins move afterwards; the captured address must not follow
        strap = ~strap;
    endtask : hw_reset
    // code leaves two edges after the nibble is taken, the line bit one edge later
    // nrzi is checked as the change between neighbouring line bits, so its start level does not matter
    task automatic stream(input int n, input logic seq);
        logic [4:0] q[$];
        logic       msb[$];
        logic       nrzi;
        logic       prev_line;
        nrzi      = ctl[PXC_BIT_NRZI] && speed_100;
        prev_line = line_bit;
        for (int i = 0; i < n + 3; i++) begin
            @(negedge clk_sys);
            if (i >= 2) chk_code(tx_code, q.pop_front());
            if (i >= 3) chk_line(line_bit ^ (nrzi & prev_line), msb.pop_front());
            prev_line = line_bit;
            mii_tx = seq ? {1'b1, 1'b1, i[3:0]} : 6'($random(seed));
            if (i >= n) mii_tx.en = 1'b0;
            q.push_back(exp_code(mii_tx, ctl[PXC_BIT_INV_CODE]));
            msb.push_back(q[$][4]);
        end
    endtask : stream

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        hw_reset();
        sta.rd(rd);
        chk_reg(rd, exp_reg(16'h0008, cap), "reset value");
        chk_reg(phy_addr, cap, "phy address");
        for (int k = 0; k < 24; k++) begin
            ctl = 16'($random(seed));
            // streaming passes keep the scrambler out so the line bit can be predicted
            if (k % 8 == 7) begin
                ctl[PXC_BIT_INV_CODE] = (k > 8);
                ctl[PXC_BIT_SCR_DIS]  = (k != 15);
                ctl[PXC_BIT_NRZI]     = (k != 7);
                ctl[7]                = (k != 15);
            end
            speed_100 = ctl[7];
            sta.wr(PXC_REG_ADDR, ctl);
            chk_reg(ovr, ctl[PXC_BIT_OVR_EN], "override arm");
            sta.rd(rd);
            chk_reg(rd, exp_reg(ctl, cap), "readback");
            chk_reg({rx_unlock, rx_bypass}, {ctl[PXC_BIT_SCR_TEST], ctl[PXC_BIT_SCR_DIS] | !speed_100},
                    "rx");
            sta.wr(5'h00, 16'($random(seed)));
            chk_reg(ovr, 1'b0, "override self clear");
            if (k % 8 == 7) stream(32, k == 23);
        end
        sta.arm(16'h002d);
        chk_reg(ovr, 1'b1, "override rearm");
        @(negedge clk_sys);
        soft_reset = 1'b1;
        @(negedge clk_sys);
        soft_reset = 1'b0;
        sta.rd(rd);
        chk_reg(rd, exp_reg(16'h0008, cap), "soft reset");
        hw_reset();
        sta.rd(rd);
        chk_reg(rd, exp_reg(16'h0008, cap), "hard reset recapture");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
